// ---- core/timer8_pulse_pwm_modes.sv ----
// Functional notes
// [RULE_01] Single-shot select bit enables one-pulse mode using capture one and compare one.
// [RULE_02] Trigger edge reloads counter FCh, drives during level, sets capture flag, loads FDh.
// [RULE_03] Trigger-set capture flag one raises interrupt when capture enable is set.
// [RULE_04] One-pulse counter match with compare one drives after level, ending pulse.
// [RULE_05] One-pulse never sets compare flag one; compare flag two still works.
// [RULE_06] PWM select together with single-shot select gives PWM mode only.
// [RULE_07] One-pulse: pin one never captures; pin two still captures normally.
// [RULE_08] One-pulse: compare two still flags time but drives no output waveform.
// [RULE_09] PWM uses whole compare one channel and compare value two register.
// [RULE_10] PWM compare values are double buffered, applied at compare two match.
// [RULE_11] PWM: match one drives level one, match two drives level two.
// [RULE_12] Level one high, level two low gives pulse width compare two minus one.
// [RULE_13] PWM compare two match reloads counter with FCh.
// [RULE_14] PWM never sets either compare flag.
// [RULE_15] PWM compare two match sets capture flag one, may interrupt.
// [RULE_16] PWM disconnects capture pin one; capture pin two still captures.
// [RULE_17] Period is compare value plus five ticks; prescale 2, 4, 8 or 8000.
// [RULE_18] Wait mode leaves timer running; enabled interrupt wakes from wait.
// [RULE_19] Halt freezes registers and counting; resumes from held count.
// [RULE_20] Capture edge in halt arms capture; exit sets flag and captures count.
// [RULE_21] One shared interrupt; each flag gated by its enable; wakes wait not halt.
// [RULE_22] Clock select: 00 div 4, 01 div 2, 10 div 8, 11 div 8000.
// [RULE_23] Edge select one: 0 falling, 1 rising edge on capture pin one.
// [RULE_24] Pin enable one only routes output; compare one stays active.
// [RULE_25] Counter increments each tick, wraps to zero and sets overflow flag.
`default_nettype none
module timer8_pulse_pwm_modes
  import timer8_pkg::*;
#(
  parameter int unsigned SLOW_DIV = DIV_SLOW,
  parameter int unsigned PRESC_W = 13
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // APB slave.
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Timer pins.
  input wire logic capture_pin_one_i,
  input wire logic capture_pin_two_i,
  output logic compare_output_pin_one_o,
  output logic compare_output_pin_one_oe_o,
  output logic compare_output_pin_two_o,
  output logic compare_output_pin_two_oe_o,
  // System signals.
  output logic timer_irq_o,
  output logic wait_wake_o
);

  // ****************************************************************
  // Registers and decoded controls.
  // ****************************************************************
  logic [7:0] timer_control_one_r;
  logic [7:0] timer_control_two_r;
  logic timer_disable_r;
  logic [7:0] power_r;
  logic [7:0] compare_value_one_r;
  logic [7:0] compare_value_two_r;
  logic [7:0] cmp_one_act_r;
  logic [7:0] cmp_two_act_r;
  logic [7:0] capture_value_one_r;
  logic [7:0] capture_value_two_r;
  logic [7:0] count_r;
  logic [PRESC_W-1:0] presc_r;
  logic [4:0] flags_r;
  logic [4:0] clr_arm_r;
  logic [1:0] halt_arm_r;
  logic cap_one_prev_r;
  logic cap_two_prev_r;
  logic halt_prev_r;
  logic level_one_r;
  logic level_two_r;

  logic pwm_mode;
  logic shot_mode;
  logic normal_mode;
  logic halted;
  logic run;
  logic tick;
  logic halt_exit;
  logic edge_one;
  logic edge_two;
  logic shot_trig;
  logic match_one;
  logic match_two;
  logic wrap;
  logic [PRESC_W-1:0] div_sel;
  logic [7:0] cmp_one_use;
  logic [7:0] cmp_two_use;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic irq_pend;

  assign pwm_mode = timer_control_two_r[CR2_PWM]; // [RULE_06] [RULE_09]
  assign shot_mode = timer_control_two_r[CR2_SINGLE_SHOT] & ~pwm_mode; // [RULE_01] [RULE_06]
  assign normal_mode = ~pwm_mode & ~shot_mode;
  assign halted = power_r[POWER_HALT];
  assign run = ~halted & ~timer_disable_r; // [RULE_18] [RULE_19]
  assign halt_exit = halt_prev_r & ~halted;

  // ****************************************************************
  // APB access.
  // ****************************************************************
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic hit;
  logic [7:0] rd_data;

  assign acc = psel_i & penable_i & pready_o;
  assign rd_acc = acc & ~pwrite_i;
  assign wr_acc = acc & pwrite_i;

  always_comb begin
    hit = 1'b1;
    rd_data = REG_RESET;
    unique case (paddr_i)
      ADDR_CTRL_ONE: rd_data = timer_control_one_r;
      ADDR_CTRL_TWO: rd_data = timer_control_two_r;
      ADDR_STATUS: rd_data = {flags_r, timer_disable_r, 2'b00};
      ADDR_CAP_ONE: rd_data = capture_value_one_r;
      ADDR_CMP_ONE: rd_data = compare_value_one_r;
      ADDR_CMP_TWO: rd_data = compare_value_two_r;
      ADDR_COUNT: rd_data = count_r;
      ADDR_ALT_COUNT: rd_data = count_r;
      ADDR_CAP_TWO: rd_data = capture_value_two_r;
      ADDR_POWER: rd_data = power_r;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      prdata_o <= {24'h00_0000, rd_data};
      pslverr_o <= ~hit;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      timer_control_one_r <= REG_RESET;
      timer_control_two_r <= REG_RESET;
      timer_disable_r <= 1'b0;
      power_r <= REG_RESET;
      compare_value_one_r <= REG_RESET;
      compare_value_two_r <= REG_RESET;
    end else if (wr_acc) begin
      unique case (paddr_i)
        ADDR_CTRL_ONE: timer_control_one_r <= pwdata_i[7:0];
        ADDR_CTRL_TWO: timer_control_two_r <= pwdata_i[7:0] & CR2_WRITE_MASK;
        ADDR_STATUS: timer_disable_r <= pwdata_i[STATUS_DISABLE];
        ADDR_CMP_ONE: compare_value_one_r <= pwdata_i[7:0];
        ADDR_CMP_TWO: compare_value_two_r <= pwdata_i[7:0];
        ADDR_POWER: power_r <= {5'b00000, pwdata_i[2:0]};
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Prescaler and counter.
  // ****************************************************************
  always_comb begin
    unique case (timer_control_two_r[CR2_CLK_HI:CR2_CLK_LO]) // [RULE_22]
      CLK_DIV4: div_sel = PRESC_W'(DIV_FOUR);
      CLK_DIV2: div_sel = PRESC_W'(DIV_TWO);
      CLK_DIV8: div_sel = PRESC_W'(DIV_EIGHT);
      CLK_SLOW: div_sel = PRESC_W'(SLOW_DIV);
    endcase
  end

  assign tick = run & (presc_r >= div_sel - PRESC_W'(1)); // [RULE_17]

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      presc_r <= '0;
    end else if (run) begin // [RULE_19]
      presc_r <= tick ? '0 : presc_r + PRESC_W'(1);
    end
  end

  // Double buffers load at the period end in PWM and follow writes otherwise.
  assign cmp_one_use = pwm_mode ? cmp_one_act_r : compare_value_one_r;
  assign cmp_two_use = pwm_mode ? cmp_two_act_r : compare_value_two_r;
  assign match_one = tick & (count_r == cmp_one_use); // [RULE_24]
  assign match_two = tick & (count_r == cmp_two_use);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cmp_one_act_r <= REG_RESET;
      cmp_two_act_r <= REG_RESET;
    end else if (!pwm_mode || match_two) begin // [RULE_10]
      cmp_one_act_r <= compare_value_one_r;
      cmp_two_act_r <= compare_value_two_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cap_one_prev_r <= 1'b0;
      cap_two_prev_r <= 1'b0;
      halt_prev_r <= 1'b0;
    end else begin
      cap_one_prev_r <= capture_pin_one_i;
      cap_two_prev_r <= capture_pin_two_i;
      halt_prev_r <= halted;
    end
  end

  assign edge_one = timer_control_one_r[CR1_EDGE_ONE] ?
                    (capture_pin_one_i & ~cap_one_prev_r) :
                    (~capture_pin_one_i & cap_one_prev_r); // [RULE_23]
  assign edge_two = timer_control_two_r[CR2_EDGE_TWO] ?
                    (capture_pin_two_i & ~cap_two_prev_r) :
                    (~capture_pin_two_i & cap_two_prev_r);
  assign shot_trig = shot_mode & run & edge_one; // [RULE_02]
  assign wrap = tick & (count_r == COUNT_MAX) & ~(pwm_mode & match_two) & ~shot_trig;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      count_r <= COUNT_RESET;
    end else if (wr_acc && (paddr_i == ADDR_COUNT || paddr_i == ADDR_ALT_COUNT)) begin
      count_r <= COUNT_RESET;
    end else if (shot_trig) begin
      count_r <= COUNT_RESET; // [RULE_02]
    end else if (pwm_mode && match_two) begin
      count_r <= COUNT_RESET; // [RULE_13] [RULE_17]
    end else if (tick) begin
      count_r <= count_r + 8'h01; // [RULE_25]
    end
  end

  // ****************************************************************
  // Captures, including captures armed during halt.
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      halt_arm_r <= 2'b00;
    end else if (halt_exit) begin
      halt_arm_r <= 2'b00;
    end else if (halted) begin
      halt_arm_r <= halt_arm_r | {edge_one & normal_mode, edge_two}; // [RULE_20]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      capture_value_one_r <= REG_RESET;
    end else if (shot_trig) begin
      capture_value_one_r <= SHOT_CAPTURE[7:0]; // [RULE_02]
    end else if (normal_mode && ((edge_one && !halted) || (halt_exit && halt_arm_r[1]))) begin
      capture_value_one_r <= count_r; // [RULE_07] [RULE_16] [RULE_20]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      capture_value_two_r <= REG_RESET;
    end else if ((edge_two && !halted) || (halt_exit && halt_arm_r[0])) begin
      capture_value_two_r <= count_r; // [RULE_07] [RULE_16] [RULE_20]
    end
  end

  // ****************************************************************
  // Status flags; a set in the clearing cycle wins.
  // ****************************************************************
  always_comb begin
    flag_set = 5'b00000;
    flag_set[FLAG_CAP_ONE] = shot_trig | (pwm_mode & match_two) |
                             (normal_mode & edge_one & ~halted) |
                             (halt_exit & halt_arm_r[1]); // [RULE_02] [RULE_15] [RULE_20]
    flag_set[FLAG_CMP_ONE] = normal_mode & match_one; // [RULE_05] [RULE_14]
    flag_set[FLAG_OVF] = wrap; // [RULE_25]
    flag_set[FLAG_CAP_TWO] = (edge_two & ~halted) | (halt_exit & halt_arm_r[0]);
    flag_set[FLAG_CMP_TWO] = ~pwm_mode & match_two; // [RULE_05] [RULE_08] [RULE_14]
    flag_clr = 5'b00000;
    flag_clr[FLAG_CAP_ONE] = acc & (paddr_i == ADDR_CAP_ONE) & clr_arm_r[FLAG_CAP_ONE];
    flag_clr[FLAG_CMP_ONE] = acc & (paddr_i == ADDR_CMP_ONE) & clr_arm_r[FLAG_CMP_ONE];
    flag_clr[FLAG_OVF] = acc & (paddr_i == ADDR_COUNT) & clr_arm_r[FLAG_OVF];
    flag_clr[FLAG_CAP_TWO] = acc & (paddr_i == ADDR_CAP_TWO) & clr_arm_r[FLAG_CAP_TWO];
    flag_clr[FLAG_CMP_TWO] = acc & (paddr_i == ADDR_CMP_TWO) & clr_arm_r[FLAG_CMP_TWO];
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      flags_r <= 5'b00000;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      clr_arm_r <= 5'b00000;
    end else if (rd_acc && paddr_i == ADDR_STATUS) begin
      clr_arm_r <= flags_r;
    end else begin
      clr_arm_r <= clr_arm_r & ~flag_clr;
    end
  end

  // ****************************************************************
  // Output level latches and pins.
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      level_one_r <= 1'b0;
    end else if (pwm_mode) begin
      if (match_two) begin
        level_one_r <= timer_control_one_r[CR1_LEVEL_TWO]; // [RULE_11] [RULE_12]
      end else if (match_one) begin
        level_one_r <= timer_control_one_r[CR1_LEVEL_ONE]; // [RULE_11] [RULE_12]
      end
    end else if (shot_mode) begin
      if (shot_trig) begin
        level_one_r <= timer_control_one_r[CR1_LEVEL_TWO]; // [RULE_02]
      end else if (match_one) begin
        level_one_r <= timer_control_one_r[CR1_LEVEL_ONE]; // [RULE_04]
      end
    end else if (match_one || (run && timer_control_one_r[CR1_FORCE_ONE])) begin
      level_one_r <= timer_control_one_r[CR1_LEVEL_ONE];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      level_two_r <= 1'b0;
    end else if (normal_mode && (match_two || (run && timer_control_one_r[CR1_FORCE_TWO]))) begin
      level_two_r <= timer_control_one_r[CR1_LEVEL_TWO]; // [RULE_08]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      compare_output_pin_one_o <= 1'b0;
      compare_output_pin_one_oe_o <= 1'b0;
      compare_output_pin_two_o <= 1'b0;
      compare_output_pin_two_oe_o <= 1'b0;
    end else begin
      compare_output_pin_one_oe_o <= timer_control_two_r[CR2_PIN_EN_ONE] & ~timer_disable_r;
      compare_output_pin_one_o <= timer_control_two_r[CR2_PIN_EN_ONE] & ~timer_disable_r &
                                  level_one_r; // [RULE_24]
      compare_output_pin_two_oe_o <= timer_control_two_r[CR2_PIN_EN_TWO] & ~timer_disable_r;
      compare_output_pin_two_o <= timer_control_two_r[CR2_PIN_EN_TWO] & ~timer_disable_r &
                                  level_two_r;
    end
  end

  // ****************************************************************
  // Shared interrupt and wake from wait.
  // ****************************************************************
  assign irq_pend = ((flags_r[FLAG_CAP_ONE] | flags_r[FLAG_CAP_TWO]) &
                     timer_control_one_r[CR1_CAP_IRQ_EN]) |
                    ((flags_r[FLAG_CMP_ONE] | flags_r[FLAG_CMP_TWO]) &
                     timer_control_one_r[CR1_CMP_IRQ_EN]) |
                    (flags_r[FLAG_OVF] & timer_control_one_r[CR1_OVF_IRQ_EN]); // [RULE_21]

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      timer_irq_o <= 1'b0;
      wait_wake_o <= 1'b0;
    end else begin
      timer_irq_o <= irq_pend & ~power_r[POWER_MASK]; // [RULE_03] [RULE_15] [RULE_21]
      wait_wake_o <= irq_pend & power_r[POWER_WAIT] & ~halted; // [RULE_18] [RULE_21]
    end
  end

endmodule
`default_nettype wire

// ---- pkg/timer8_pkg.sv ----
`default_nettype none
package timer8_pkg;
  // ****************************************************************
  // Register byte addresses.
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAP_ONE = 8'h0C;
  localparam logic [7:0] ADDR_CMP_ONE = 8'h10;
  localparam logic [7:0] ADDR_CMP_TWO = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_ALT_COUNT = 8'h1C;
  localparam logic [7:0] ADDR_CAP_TWO = 8'h20;
  localparam logic [7:0] ADDR_POWER = 8'h24;
  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CR1_CAP_IRQ_EN = 7;
  localparam int CR1_CMP_IRQ_EN = 6;
  localparam int CR1_OVF_IRQ_EN = 5;
  localparam int CR1_FORCE_TWO = 4;
  localparam int CR1_LEVEL_TWO = 2;
  localparam int CR1_EDGE_ONE = 1;
  localparam int CR1_LEVEL_ONE = 0;
  localparam int CR2_PIN_EN_ONE = 7;
  localparam int CR2_PIN_EN_TWO = 6;
  localparam int CR2_SINGLE_SHOT = 5;
  localparam int CR2_PWM = 4;
  localparam int CR2_CLK_HI = 3;
  localparam int CR2_CLK_LO = 2;
  localparam int CR2_EDGE_TWO = 1;
  localparam int CR1_FORCE_ONE = 3;
  localparam logic [7:0] CR2_WRITE_MASK = 8'hFE;
  localparam int FLAG_CAP_ONE = 4;
  localparam int FLAG_CMP_ONE = 3;
  localparam int FLAG_OVF = 2;
  localparam int FLAG_CAP_TWO = 1;
  localparam int FLAG_CMP_TWO = 0;
  localparam int STATUS_DISABLE = 2;
  localparam int POWER_HALT = 0;
  localparam int POWER_WAIT = 1;
  localparam int POWER_MASK = 2;
  // ****************************************************************
  // Reset values and counts.
  // ****************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'hFC;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [15:0] SHOT_CAPTURE = 16'hFFFD;
  localparam int PERIOD_EXTRA = 5;
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_SLOW = 2'b11;
  localparam int DIV_TWO = 2;
  localparam int DIV_FOUR = 4;
  localparam int DIV_EIGHT = 8;
  localparam int DIV_SLOW = 8000;
endpackage
`default_nettype wire

// ---- testbench/pulse_load_model.sv ----
`default_nettype none
module pulse_load_model (
  // Clock and commands.
  input wire logic mclk_i,
  input wire logic fire_one_i,
  input wire logic fire_two_i,
  // Load side.
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // Trigger side.
  output logic capture_pin_one_o,
  output logic capture_pin_two_o,
  // Measurements.
  output int high_len_o,
  output int period_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b0;
  int run = 0;
  int since = 0;
  initial begin
    capture_pin_one_o = 1'b0;
    capture_pin_two_o = 1'b0;
    high_len_o = 0;
    period_o = 0;
  end
  // ****
  // Trigger edges and pulse timing.
  // ****
  always @(posedge mclk_i) begin
    if (fire_one_i) capture_pin_one_o <= ~capture_pin_one_o;
    if (fire_two_i) capture_pin_two_o <= ~capture_pin_two_o;
    prev <= pin_i;
    if (pin_oe_i && pin_i && !prev) begin
      period_o <= since;
      since <= 1;
      run <= 1;
    end else begin
      since <= since + 1;
      if (pin_i) run <= run + 1;
    end
    if (!pin_i && prev) high_len_o <= run;
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb
  import timer8_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, timer_irq_o, wait_wake_o;
  logic pin1, oe1, pin2, oe2, cap1, cap2;
  logic fire_one = 1'b0;
  logic fire_two = 1'b0;
  int high_len, period;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] rd, cnt;
  logic err;
  `define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
  always #2 mclk_i = ~mclk_i;
  timer8_pulse_pwm_modes #(.SLOW_DIV(16)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .capture_pin_one_i(cap1),
    .capture_pin_two_i(cap2), .compare_output_pin_one_o(pin1),
    .compare_output_pin_one_oe_o(oe1), .compare_output_pin_two_o(pin2),
    .compare_output_pin_two_oe_o(oe2), .timer_irq_o(timer_irq_o), .wait_wake_o(wait_wake_o));
  pulse_load_model u_load (
    .mclk_i(mclk_i), .fire_one_i(fire_one), .fire_two_i(fire_two), .pin_i(pin1),
    .pin_oe_i(oe1), .capture_pin_one_o(cap1), .capture_pin_two_o(cap2),
    .high_len_o(high_len), .period_o(period));
  // ****
  // Bus and pin tasks.
  // ****
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= {24'h000000, d};
    psel_i <= 1'b1;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic pulse_pin(input logic two);
    if (two) fire_two <= 1'b1;
    else fire_one <= 1'b1;
    @(posedge mclk_i);
    fire_one <= 1'b0;
    fire_two <= 1'b0;
  endtask
  task automatic pwm_run(input logic [7:0] c1, input logic [7:0] c2);
    apb(ADDR_CMP_ONE, 1'b1, c1);
    apb(ADDR_CMP_TWO, 1'b1, c2);
    idle(700);
    `CHK("pwm period", (int'(c2) + PERIOD_EXTRA) * DIV_TWO, period)
    `CHK("pwm high", (int'(c2) - int'(c1)) * DIV_TWO, high_len)
  endtask
  // ****
  // Main sequence.
  // ****
  initial begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    apb(ADDR_CTRL_ONE, 1'b0, 8'h00);
    `CHK("ctrl one reset", {24'h0, REG_RESET}, rd)
    apb(8'h28, 1'b0, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(ADDR_CMP_ONE, 1'b1, 8'h20);
    apb(ADDR_CTRL_ONE, 1'b1, 8'h86);
    apb(ADDR_CTRL_TWO, 1'b1, 8'hA6);
    pulse_pin(1'b0);
    idle(6);
    `CHK("pulse start", 1'b1, pin1)
    `CHK("trigger irq", 1'b1, timer_irq_o)
    pulse_pin(1'b1);
    idle(100);
    `CHK("pulse end", 1'b0, pin1)
    apb(ADDR_STATUS, 1'b0, 8'h00);
    `CHK("trigger flag", 1'b1, rd[3 + FLAG_CAP_ONE])
    `CHK("compare one flag", 1'b0, rd[3 + FLAG_CMP_ONE])
    `CHK("capture two flag", 1'b1, rd[3 + FLAG_CAP_TWO])
    `CHK("compare two flag", 1'b1, rd[3 + FLAG_CMP_TWO])
    `CHK("pin two quiet", 2'b00, {oe2, pin2})
    apb(ADDR_CAP_ONE, 1'b0, 8'h00);
    `CHK("trigger capture", {24'h0, SHOT_CAPTURE[7:0]}, rd)
    apb(ADDR_CTRL_ONE, 1'b1, 8'h81);
    apb(ADDR_CTRL_TWO, 1'b1, 8'hB4);
    apb(ADDR_STATUS, 1'b0, 8'h00);
    pwm_run(8'h08, 8'h18);
    apb(ADDR_STATUS, 1'b0, 8'h00);
    `CHK("pwm compare flags", 2'b00, {rd[3 + FLAG_CMP_ONE], rd[3 + FLAG_CMP_TWO]})
    `CHK("pwm period flag", 1'b1, rd[3 + FLAG_CAP_ONE])
    `CHK("pwm irq", 1'b1, timer_irq_o)
    pwm_run(8'h10, 8'h28);
    apb(ADDR_POWER, 1'b1, 8'h02);
    idle(3);
    `CHK("wake from wait", 1'b1, wait_wake_o)
    apb(ADDR_POWER, 1'b1, 8'h03);
    idle(3);
    `CHK("no wake in halt", 1'b0, wait_wake_o)
    apb(ADDR_COUNT, 1'b0, 8'h00);
    cnt = rd;
    idle(50);
    apb(ADDR_COUNT, 1'b0, 8'h00);
    `CHK("halt freeze", cnt, rd)
    pulse_pin(1'b1);
    idle(2);
    apb(ADDR_POWER, 1'b1, 8'h04);
    idle(3);
    `CHK("masked irq", 1'b0, timer_irq_o)
    apb(ADDR_CAP_TWO, 1'b0, 8'h00);
    `CHK("halt capture", cnt, rd)
    apb(ADDR_POWER, 1'b1, 8'h00);
    idle(3);
    `CHK("unmasked irq", 1'b1, timer_irq_o)
    final_report();
  end
endmodule
bind timer8_pulse_pwm_modes timer8_checker u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .compare_output_pin_one_o(compare_output_pin_one_o),
  .compare_output_pin_one_oe_o(compare_output_pin_one_oe_o),
  .compare_output_pin_two_o(compare_output_pin_two_o),
  .compare_output_pin_two_oe_o(compare_output_pin_two_oe_o));
`default_nettype wire

// ---- testbench/timer8_sva.sv ----
`default_nettype none
module timer8_checker
  import timer8_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Bus.
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins.
  input wire logic compare_output_pin_one_o,
  input wire logic compare_output_pin_one_oe_o,
  input wire logic compare_output_pin_two_o,
  input wire logic compare_output_pin_two_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_seen;
  assign wr_seen = psel_i && pwrite_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // ****
  // Bus handshake.
  // ****
  sequence s_wait;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_done;
    pready_o ##1 !pready_o;
  endsequence
  property p_one_wait;
    s_wait |=> s_done;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");
  property p_idle;
    !(psel_i && penable_i) |=> !pready_o;
  endproperty
  a_idle: assert property (p_idle) else $error("ready without access");
  property p_err_map;
    pready_o && (paddr_i[1:0] != 2'h0 || paddr_i > ADDR_POWER) |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_ok_map;
    pready_o && paddr_i[1:0] == 2'h0 && paddr_i <= ADDR_POWER |-> !pslverr_o;
  endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
  property p_upper;
    pready_o |-> prdata_o[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  // ****
  // Pin routing.
  // ****
  property p_oe_cause;
    $changed(compare_output_pin_one_oe_o) || $changed(compare_output_pin_two_oe_o)
      |-> $past(wr_seen) || $past(wr_seen, 2) || $past(wr_seen, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");
  property p_gate_one;
    !compare_output_pin_one_oe_o |-> !compare_output_pin_one_o;
  endproperty
  a_gate_one: assert property (p_gate_one) else $error("pin one driven while off");
  property p_gate_two;
    !compare_output_pin_two_oe_o |-> !compare_output_pin_two_o;
  endproperty
  a_gate_two: assert property (p_gate_two) else $error("pin two driven while off");
endmodule
`default_nettype wire
